// ==== hw/pin_cell.sv ====
// one port line: direction bit, output latch, driver select, input sampling
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
  input wire logic clk,
  input wire logic rst,
  input wire logic latch_we,
  input wire logic latch_wd,
  input wire logic dir_we,
  input wire logic dir_wd,
  input wire logic alt_en,
  input wire logic alt_data,
  input wire logic hw_dir_en,
  input wire logic hw_dir_out,
  input wire logic on_chip_extension_bus_en,
  input wire logic on_chip_extension_bus_oe,
  input wire logic on_chip_extension_bus_data,
  input wire logic pin_in,
  output logic pin_out_r,
  output logic pin_oe_r,
  output logic alt_in_r,
  output logic latch_r,
  output logic dir_r
);
  import pin_mux_pkg::*;

  logic sync1_r;
  logic sync2_r;
  wire logic eff_dir;
  wire logic drv_val;
  wire logic pin_out_nxt;
  wire logic pin_oe_nxt;
  wire logic alt_in_nxt;

  // hardware-switched lines ignore the direction bit for the pin enable, but the alternate input still follows it
  assign eff_dir = hw_dir_en ? hw_dir_out : dir_r;
  // hardware-switched lines are not reachable by software, so the latch is bypassed there
  assign drv_val = hw_dir_en ? alt_data : (alt_en ? (latch_r & alt_data) : latch_r);
  // extension-bus peripherals own enable and data outright
  assign pin_oe_nxt = on_chip_extension_bus_en ? on_chip_extension_bus_oe : eff_dir;
  assign pin_out_nxt = on_chip_extension_bus_en ? on_chip_extension_bus_data : drv_val;
  // in output direction the alternate input sees the latch, not the pin
  assign alt_in_nxt = dir_r ? latch_r : sync2_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_r <= DIR_RESET;
      latch_r <= LATCH_RESET;
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
      pin_out_r <= LATCH_RESET;
      pin_oe_r <= DIR_RESET;
      alt_in_r <= SYNC_RESET;
    end else begin
      if (dir_we) begin
        dir_r <= dir_wd;
      end
      if (latch_we) begin
        latch_r <= latch_wd;
      end
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      alt_in_r <= alt_in_nxt;
    end
  end

endmodule : pin_cell
`default_nettype wire

// ==== hw/pin_mux_pkg.sv ====
// constants shared by the port alternate function multiplexer
package pin_mux_pkg;

  // pin map of the flat pin vector
  localparam int BUS_PORT_LSB = 0;
  localparam int BUS_PORT_W = 16;
  localparam int ADDR_PORT_LSB = 16;
  localparam int ADDR_PORT_W = 16;
  localparam int IRQ_PORT_LSB = 32;
  localparam int IRQ_PORT_W = 8;
  localparam int SEG_PORT_LSB = 40;
  localparam int SEG_PORT_W = 8;
  localparam int SEG_ADDR_W = 7;
  localparam int SEL_PORT_LSB = 48;
  localparam int SEL_PORT_W = 8;
  localparam int CHIP_SEL_W = 5;
  localparam int I2C_DATA_BIT = 5;
  localparam int I2C_CLK_BIT = 6;
  localparam int PIN_COUNT = 56;

  // reset values of the per-pin state
  localparam logic DIR_RESET = 1'h0;
  localparam logic LATCH_RESET = 1'h0;
  localparam logic SYNC_RESET = 1'h0;

endpackage : pin_mux_pkg

// ==== hw/port_alternate_function_mux.sv ====
// port pin multiplexer between general purpose IO and alternate functions
`timescale 1ns/1ps
`default_nettype none
module port_alternate_function_mux (
  input wire logic clk,
  input wire logic rst,
  // pins, flat over all ports
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] pin_in,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] pin_out,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] pin_oe,
  // per-pin software writes of latch and direction
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] latch_we,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] latch_wdata,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] dir_we,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] dir_wdata,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] latch_q,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] pin_direction_bit,
  // multiplexed bus port
  input wire logic bus_ad_enable,
  input wire logic bus_ad_drive,
  input wire logic [pin_mux_pkg::BUS_PORT_W-1:0] bus_ad_out,
  output logic [pin_mux_pkg::BUS_PORT_W-1:0] bus_ad_in,
  // address port
  input wire logic addr_enable,
  input wire logic [pin_mux_pkg::ADDR_PORT_W-1:0] addr_out,
  // fast interrupt inputs
  output logic [pin_mux_pkg::IRQ_PORT_W-1:0] fast_irq_input,
  // segment address
  input wire logic [pin_mux_pkg::SEG_ADDR_W-1:0] seg_enable,
  input wire logic [pin_mux_pkg::SEG_ADDR_W-1:0] seg_addr_out,
  // chip selects and serial lines
  input wire logic [pin_mux_pkg::CHIP_SEL_W-1:0] chip_sel_enable,
  input wire logic [pin_mux_pkg::CHIP_SEL_W-1:0] chip_sel_out,
  input wire logic i2c_enable,
  input wire logic i2c_data_out,
  input wire logic i2c_clk_out,
  output logic i2c_data_in,
  output logic i2c_clk_in,
  // extension-bus peripheral control lines
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] on_chip_extension_bus_ctl_en,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] on_chip_extension_bus_oe,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] on_chip_extension_bus_out
);
  import pin_mux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin control vectors, filled one port slice at a time
  // a line with no alternate function keeps alt_en low and works from its latch

  wire logic [PIN_COUNT-1:0] alt_en;
  wire logic [PIN_COUNT-1:0] alt_data;
  wire logic [PIN_COUNT-1:0] hw_dir_en;
  wire logic [PIN_COUNT-1:0] hw_dir_out;
  wire logic [PIN_COUNT-1:0] alt_in;

  ////////////////////////////////////////////////////////////////////////////
  // bus port: address then data, direction turned by the bus controller

  wire logic [BUS_PORT_W-1:0] bus_en_vec;
  wire logic [BUS_PORT_W-1:0] bus_dir_vec;

  assign bus_en_vec = {BUS_PORT_W{bus_ad_enable}};
  assign bus_dir_vec = {BUS_PORT_W{bus_ad_drive}};

  assign alt_en[BUS_PORT_LSB +: BUS_PORT_W] = bus_en_vec;
  // software cannot reach these lines in bus mode, so the cell bypasses the latch
  assign alt_data[BUS_PORT_LSB +: BUS_PORT_W] = bus_ad_out;
  // instructions are far too slow to turn the lines between address and data
  assign hw_dir_en[BUS_PORT_LSB +: BUS_PORT_W] = bus_en_vec;
  assign hw_dir_out[BUS_PORT_LSB +: BUS_PORT_W] = bus_dir_vec;

  ////////////////////////////////////////////////////////////////////////////
  // address port: plain alternate output under the direction bit

  wire logic [ADDR_PORT_W-1:0] addr_en_vec;
  wire logic [ADDR_PORT_W-1:0] addr_hw_vec;

  assign addr_en_vec = {ADDR_PORT_W{addr_enable}};
  assign addr_hw_vec = {ADDR_PORT_W{1'h0}};

  assign alt_en[ADDR_PORT_LSB +: ADDR_PORT_W] = addr_en_vec;
  assign alt_data[ADDR_PORT_LSB +: ADDR_PORT_W] = addr_out;
  // no hardware direction: lines stay undriven until software sets them to output
  assign hw_dir_en[ADDR_PORT_LSB +: ADDR_PORT_W] = addr_hw_vec;
  assign hw_dir_out[ADDR_PORT_LSB +: ADDR_PORT_W] = addr_hw_vec;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt port: inputs only, so its outputs stay general purpose

  wire logic [IRQ_PORT_W-1:0] irq_off_vec;

  assign irq_off_vec = {IRQ_PORT_W{1'h0}};

  assign alt_en[IRQ_PORT_LSB +: IRQ_PORT_W] = irq_off_vec;
  assign alt_data[IRQ_PORT_LSB +: IRQ_PORT_W] = irq_off_vec;
  assign hw_dir_en[IRQ_PORT_LSB +: IRQ_PORT_W] = irq_off_vec;
  assign hw_dir_out[IRQ_PORT_LSB +: IRQ_PORT_W] = irq_off_vec;

  ////////////////////////////////////////////////////////////////////////////
  // segment address port, top line left for general purpose use
  // only wide systems enable these; narrow ones leave the lines to software

  wire logic [SEG_PORT_W-1:0] seg_en_vec;
  wire logic [SEG_PORT_W-1:0] seg_data_vec;
  wire logic [SEG_PORT_W-1:0] seg_hw_vec;

  assign seg_en_vec[SEG_ADDR_W-1:0] = seg_enable;
  assign seg_en_vec[SEG_PORT_W-1:SEG_ADDR_W] = {(SEG_PORT_W-SEG_ADDR_W){1'h0}};
  assign seg_data_vec[SEG_ADDR_W-1:0] = seg_addr_out;
  assign seg_data_vec[SEG_PORT_W-1:SEG_ADDR_W] = {(SEG_PORT_W-SEG_ADDR_W){1'h0}};
  assign seg_hw_vec = {SEG_PORT_W{1'h0}};

  assign alt_en[SEG_PORT_LSB +: SEG_PORT_W] = seg_en_vec;
  assign alt_data[SEG_PORT_LSB +: SEG_PORT_W] = seg_data_vec;
  assign hw_dir_en[SEG_PORT_LSB +: SEG_PORT_W] = seg_hw_vec;
  assign hw_dir_out[SEG_PORT_LSB +: SEG_PORT_W] = seg_hw_vec;

  ////////////////////////////////////////////////////////////////////////////
  // select port: chip selects and serial lines

  wire logic [SEL_PORT_W-1:0] sel_en_vec;
  wire logic [SEL_PORT_W-1:0] sel_data_vec;
  wire logic [SEL_PORT_W-1:0] sel_hw_vec;

  // serial lines are push-pull here; the top line has no alternate function
  assign sel_en_vec[CHIP_SEL_W-1:0] = chip_sel_enable;
  assign sel_en_vec[I2C_DATA_BIT] = i2c_enable;
  assign sel_en_vec[I2C_CLK_BIT] = i2c_enable;
  assign sel_en_vec[SEL_PORT_W-1] = 1'h0;

  assign sel_data_vec[CHIP_SEL_W-1:0] = chip_sel_out;
  assign sel_data_vec[I2C_DATA_BIT] = i2c_data_out;
  assign sel_data_vec[I2C_CLK_BIT] = i2c_clk_out;
  assign sel_data_vec[SEL_PORT_W-1] = 1'h0;

  // chip selects are live right after reset, so they drive without a direction write
  assign sel_hw_vec[CHIP_SEL_W-1:0] = chip_sel_enable;
  assign sel_hw_vec[SEL_PORT_W-1:CHIP_SEL_W] = {(SEL_PORT_W-CHIP_SEL_W){1'h0}};

  assign alt_en[SEL_PORT_LSB +: SEL_PORT_W] = sel_en_vec;
  assign alt_data[SEL_PORT_LSB +: SEL_PORT_W] = sel_data_vec;
  assign hw_dir_en[SEL_PORT_LSB +: SEL_PORT_W] = sel_hw_vec;
  assign hw_dir_out[SEL_PORT_LSB +: SEL_PORT_W] = sel_hw_vec;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin cells

  // every line is the same cell; port roles come only from the vectors above
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
      pin_cell u_cell (
        .clk(clk),
        .rst(rst),
        // software writes
        .latch_we(latch_we[gi]),
        .latch_wd(latch_wdata[gi]),
        .dir_we(dir_we[gi]),
        .dir_wd(dir_wdata[gi]),
        // alternate function side
        .alt_en(alt_en[gi]),
        .alt_data(alt_data[gi]),
        .hw_dir_en(hw_dir_en[gi]),
        .hw_dir_out(hw_dir_out[gi]),
        // extension-bus takeover
        .on_chip_extension_bus_en(on_chip_extension_bus_ctl_en[gi]),
        .on_chip_extension_bus_oe(on_chip_extension_bus_oe[gi]),
        .on_chip_extension_bus_data(on_chip_extension_bus_out[gi]),
        // pin side and registered results
        .pin_in(pin_in[gi]),
        .pin_out_r(pin_out[gi]),
        .pin_oe_r(pin_oe[gi]),
        .alt_in_r(alt_in[gi]),
        .latch_r(latch_q[gi]),
        .dir_r(pin_direction_bit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // alternate inputs, each already a flip-flop inside its cell

  wire logic [BUS_PORT_W-1:0] bus_in_vec;
  wire logic [IRQ_PORT_W-1:0] irq_in_vec;
  wire logic [SEL_PORT_W-1:0] sel_in_vec;

  // in output direction these follow the latch, which lets software trigger them
  assign bus_in_vec = alt_in[BUS_PORT_LSB +: BUS_PORT_W];
  assign irq_in_vec = alt_in[IRQ_PORT_LSB +: IRQ_PORT_W];
  assign sel_in_vec = alt_in[SEL_PORT_LSB +: SEL_PORT_W];

  assign bus_ad_in = bus_in_vec;
  assign fast_irq_input = irq_in_vec;
  assign i2c_data_in = sel_in_vec[I2C_DATA_BIT];
  assign i2c_clk_in = sel_in_vec[I2C_CLK_BIT];

endmodule : port_alternate_function_mux
`default_nettype wire

// ==== tb/pin_mux_properties.sv ====
// concurrent checks on the port multiplexer pins
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [PIN_COUNT-1:0] pin_in,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] latch_we,
  input wire logic [PIN_COUNT-1:0] latch_wdata,
  input wire logic [PIN_COUNT-1:0] dir_we,
  input wire logic [PIN_COUNT-1:0] dir_wdata,
  input wire logic [PIN_COUNT-1:0] latch_q,
  input wire logic [PIN_COUNT-1:0] pin_direction_bit,
  input wire logic bus_ad_enable,
  input wire logic bus_ad_drive,
  input wire logic [BUS_PORT_W-1:0] bus_ad_out,
  input wire logic addr_enable,
  input wire logic [ADDR_PORT_W-1:0] addr_out,
  input wire logic [IRQ_PORT_W-1:0] fast_irq_input,
  input wire logic [SEG_ADDR_W-1:0] seg_enable,
  input wire logic [SEG_ADDR_W-1:0] seg_addr_out,
  input wire logic [CHIP_SEL_W-1:0] chip_sel_enable,
  input wire logic [CHIP_SEL_W-1:0] chip_sel_out,
  input wire logic i2c_enable,
  input wire logic i2c_data_out,
  input wire logic i2c_clk_out,
  input wire logic [PIN_COUNT-1:0] on_chip_extension_bus_ctl_en,
  input wire logic [PIN_COUNT-1:0] on_chip_extension_bus_oe,
  input wire logic [PIN_COUNT-1:0] on_chip_extension_bus_out
);
  // expected pin state worked out from the inputs of the same cycle
  wire logic [PIN_COUNT-1:0] hw = {3'h0, chip_sel_enable, 32'h0, {16{bus_ad_enable}}};
  wire logic [PIN_COUNT-1:0] hw_out = {{40{1'h1}}, {16{bus_ad_drive}}};
  wire logic [PIN_COUNT-1:0] alt = {1'h0, {2{i2c_enable}}, 6'h0, seg_enable, 8'h0, {16{addr_enable}}, 16'h0};
  wire logic [PIN_COUNT-1:0] alt_d = {1'h0, i2c_clk_out, i2c_data_out, chip_sel_out, 1'h0, seg_addr_out, 8'h0,
    addr_out, bus_ad_out};
  wire logic [PIN_COUNT-1:0] drv = (hw & alt_d) | (~hw & latch_q & (~alt | alt_d));
  wire logic [PIN_COUNT-1:0] eff = (hw & hw_out) | (~hw & pin_direction_bit);
  wire logic [PIN_COUNT-1:0] exp_oe = (on_chip_extension_bus_ctl_en & on_chip_extension_bus_oe) | (~on_chip_extension_bus_ctl_en & eff);
  wire logic [PIN_COUNT-1:0] exp_out = (on_chip_extension_bus_ctl_en & on_chip_extension_bus_out) | (~on_chip_extension_bus_ctl_en & drv);
  wire logic [PIN_COUNT-1:0] exp_dir = (pin_direction_bit & ~dir_we) | (dir_wdata & dir_we);
  wire logic [PIN_COUNT-1:0] exp_lat = (latch_q & ~latch_we) | (latch_wdata & latch_we);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_run; (!rst) [*4]; endsequence
  property p_rst_dir; disable iff (1'h0) rst |=> pin_direction_bit == '0; endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("direction not cleared by reset");
  property p_rst_oe; disable iff (1'h0) rst |=> pin_oe == '0; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pin driven during reset");
  property p_dir; !$past(rst) |-> pin_direction_bit == $past(exp_dir); endproperty
  a_dir: assert property (p_dir) else $error("direction bit write wrong");
  property p_lat; !$past(rst) |-> latch_q == $past(exp_lat); endproperty
  a_lat: assert property (p_lat) else $error("latch write wrong");
  property p_oe; !$past(rst) |-> pin_oe == $past(exp_oe); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_out; !$past(rst) |-> pin_out == $past(exp_out); endproperty
  a_out: assert property (p_out) else $error("pin value wrong");
  property p_irq_lat; !$past(rst) |-> ((fast_irq_input ^ $past(latch_q[39:32])) &
    $past(pin_direction_bit[39:32])) == '0; endproperty
  a_irq_lat: assert property (p_irq_lat) else $error("alternate input not from latch");
  property p_irq_pin; s_run |-> ((fast_irq_input ^ $past(pin_in[39:32], 3)) &
    ~$past(pin_direction_bit[39:32])) == '0; endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("alternate input not from pin");
endmodule : pin_mux_checker
bind port_alternate_function_mux pin_mux_checker chk_u (.*);
`default_nettype wire

// ==== tb/pin_partner.sv ====
// external devices on the pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner
  import pin_mux_pkg::*;
(
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] ext_en,
  input wire logic [PIN_COUNT-1:0] ext_val,
  output logic [PIN_COUNT-1:0] pin_lvl
);
  // a floating line shows the inverse so a stale level never passes
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & ~pin_out)));
endmodule : pin_partner
`default_nettype wire

// ==== tb/port_alternate_function_mux_bench.sv ====
// self-checking bench for the port multiplexer
`timescale 1ns/1ps
`default_nettype none
module port_alternate_function_mux_bench;
  import pin_mux_pkg::*;
  logic clk, rst, bus_ad_enable, bus_ad_drive, addr_enable, i2c_enable, i2c_data_out, i2c_clk_out;
  logic i2c_data_in, i2c_clk_in;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, latch_we, latch_wdata, dir_we, dir_wdata, latch_q;
  logic [PIN_COUNT-1:0] pin_direction_bit, on_chip_extension_bus_ctl_en, on_chip_extension_bus_oe, on_chip_extension_bus_out, ext_en, ext_val;
  logic [15:0] bus_ad_out, bus_ad_in, addr_out;
  logic [7:0] fast_irq_input;
  logic [6:0] seg_enable, seg_addr_out;
  logic [4:0] chip_sel_enable, chip_sel_out;
  int n_fail, n_checks;
  port_alternate_function_mux dut_u (.*);
  pin_partner ext_u (.pin_lvl(pin_in), .*);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(logic [PIN_COUNT-1:0] seen, logic [PIN_COUNT-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // d=1 writes direction bits, d=0 latch bits; returns once pins follow
  task automatic wr(logic d, logic [PIN_COUNT-1:0] m, logic [PIN_COUNT-1:0] v);
    if (d) {dir_we, dir_wdata} = {m, v};
    else {latch_we, latch_wdata} = {m, v};
    tick;
    {dir_we, latch_we} = '0;
    tick;
  endtask : wr
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  task automatic t_out();
    {addr_enable, addr_out, seg_enable, seg_addr_out} = {17'h1A5C3, 14'h3FD5};
    {i2c_enable, i2c_data_out, i2c_clk_out} = 3'h6;
    wr(0, 56'h1 << 47, '1);
    wr(0, 56'h60_7F00_FFFF_0000, '1);
    chk(pin_oe, '0);
    wr(1, 56'h60_FF00_FFFF_0000, '1);
    chk(pin_oe, 56'h60_FF00_FFFF_0000);
    chk(pin_out, 56'h20_D500_A5C3_0000);
    chk({i2c_clk_in, i2c_data_in}, 2'h3);
    wr(0, 56'h1 << 16, '0);
    chk(pin_out[31:16], 16'hA5C2);
    wr(1, 56'h1 << 47, '0);
    chk(pin_oe[47], 1'h0);
  endtask : t_out
  task automatic t_hw();
    {bus_ad_enable, bus_ad_drive, bus_ad_out, chip_sel_enable, chip_sel_out} = {18'h33CA5, 10'h3F5};
    tick;
    chk({pin_oe[52:48], pin_oe[15:0]}, 21'h1FFFFF);
    chk({pin_out[52:48], pin_out[15:0]}, 21'h153CA5);
    bus_ad_drive = 0;
    ext_en[15:0] = '1;
    ext_val[15:0] = 16'h5A0F;
    tick(4);
    chk(pin_oe[15:0], '0);
    chk(bus_ad_in, 16'h5A0F);
    {bus_ad_enable, chip_sel_enable, ext_en} = '0;
  endtask : t_hw
  task automatic t_in();
    ext_en[39:32] = '1;
    ext_val[39:32] = 8'h3C;
    tick(3);
    chk(fast_irq_input, 8'h3C);
    ext_en = '0;
    wr(0, 56'hFF << 32, 56'hC3 << 32);
    wr(1, 56'hFF << 32, '1);
    chk({fast_irq_input, pin_out[39:32]}, 16'hC3C3);
  endtask : t_in
  task automatic t_on_chip_extension_bus();
    {on_chip_extension_bus_ctl_en, on_chip_extension_bus_oe, on_chip_extension_bus_out} = {56'h80_0000_0001, 56'h1, 56'h1};
    tick;
    chk(pin_oe & 56'h80_0000_0001, 56'h1);
    chk(pin_out & 56'h80_0000_0001, 56'h1);
  endtask : t_on_chip_extension_bus
  task automatic t_rst();
    {on_chip_extension_bus_ctl_en, on_chip_extension_bus_oe, on_chip_extension_bus_out} = '0;
    rst = 1;
    tick(2);
    chk(pin_direction_bit, '0);
    chk(pin_oe, '0);
    rst = 0;
    tick(2);
    chk(pin_oe, '0);
  endtask : t_rst
  initial begin
    rst = 1;
    {latch_we, latch_wdata, dir_we, dir_wdata, on_chip_extension_bus_ctl_en, on_chip_extension_bus_oe, on_chip_extension_bus_out, ext_en, ext_val} = '0;
    {bus_ad_enable, bus_ad_drive, bus_ad_out, addr_enable, addr_out, seg_enable, seg_addr_out} = '0;
    {chip_sel_enable, chip_sel_out, i2c_enable, i2c_data_out, i2c_clk_out} = '0;
    tick(6);
    chk(pin_direction_bit, '0);
    chk(pin_oe, '0);
    rst = 0;
    tick;
    t_out();
    t_hw();
    t_in();
    t_on_chip_extension_bus();
    t_rst();
    conclude();
  end
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule : port_alternate_function_mux_bench
`default_nettype wire
